// *** jesd_link_param_regs.sv ***
// link parameter register slice: control bits, resolution, subclass, sample layout
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps

module jesd_link_param_regs
    import link_param_pkg::*;
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic NRST_I,
    // register port
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DATA_W-1:0] RD_DATA_O,
    output logic WR_REJECT_O,
    // link shape from neighbouring settings
    input wire logic [7:0] OCTETS_CODE_I,
    input wire logic [7:0] CONVERTERS_I,
    // link settings to the transmit framer
    output logic [2:0] CTRL_BIT_EN_O,
    output logic [1:0] CTRL_BITS_O,
    output logic [4:0] RESOLUTION_O,
    output logic [2:0] SUBCLASS_O,
    output logic [4:0] SAMPLE_BITS_O,
    output logic [4:0] SAMPLES_PER_FRAME_O,
    output logic HIGH_DENSITY_O
);

    // ********************************************************
    // storage
    // ********************************************************
    // writable fields and their next values
    logic [1:0] cs_reg;
    logic [1:0] cs_next;
    logic [4:0] res_reg;
    logic [4:0] res_next;
    logic [2:0] subclass_reg;
    logic [2:0] subclass_next;
    logic [4:0] sample_reg;
    logic [4:0] sample_next;
    // framer enables, one flop stage behind the cs code
    logic [2:0] ctrl_en_reg;
    logic [2:0] ctrl_en_next;
    // derived fields, refreshed on every edge
    logic [4:0] spf_reg;
    logic hd_reg;
    // register port answer
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic reject_reg;
    logic reject_next;

    // ********************************************************
    // helpers
    // ********************************************************
    // derived values before their flops
    logic [4:0] spf_next;
    logic hd_next;
    // address hits and field legality of the current write
    logic wr_ctrl_res;
    logic wr_sub_sample;
    logic res_ok;
    logic sample_ok;
    logic subclass_ok;
    // fields cut out of the write data
    logic [4:0] res_wr;
    logic [4:0] sample_wr;
    logic [2:0] subclass_wr;

    // control-bit lane mask for a cs code
    function automatic logic [2:0] ctrl_mask(input logic [1:0] code);
        case (ctrl_bits_e'(code))
            CS_NONE: ctrl_mask = CTRL_MASK_NONE;
            CS_ONE: ctrl_mask = CTRL_MASK_ONE;
            CS_TWO: ctrl_mask = CTRL_MASK_TWO;
            CS_ALL: ctrl_mask = CTRL_MASK_ALL;
            default: ctrl_mask = CTRL_MASK_NONE;
        endcase
    endfunction : ctrl_mask

    // legal bits-per-sample code
    function automatic logic sample_legal(input logic [4:0] code);
        sample_legal = (code == SAMPLE_CODE_8) || (code == SAMPLE_CODE_12) ||
                       (code == SAMPLE_CODE_16);
    endfunction : sample_legal

    // exact address match against one register offset
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [11:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    // ********************************************************
    // write decode
    // ********************************************************
    // address decode: a write touches at most one register
    always_comb begin
        wr_ctrl_res = WR_I && reg_hit(ADDR_I, CTRL_RES_OFS);
        wr_sub_sample = WR_I && reg_hit(ADDR_I, SUBCLASS_SAMPLE_OFS);
    end

    // fields cut out of the write data at their fixed bit positions
    always_comb begin
        res_wr = WR_DATA_I[RES_MSB:0];
        sample_wr = WR_DATA_I[SAMPLE_MSB:0];
        subclass_wr = WR_DATA_I[SUBCLASS_MSB:SUBCLASS_LSB];
    end

    // illegal codes are dropped field by field so a bad value never reaches the framer
    always_comb begin
        res_ok = (res_wr >= RES_CODE_MIN) && (res_wr <= RES_CODE_MAX);
        sample_ok = sample_legal(sample_wr);
        subclass_ok = (subclass_wr == SUBCLASS_0) || (subclass_wr == SUBCLASS_1);
    end

    // one reject pulse covers both fields; software rereads to see which one held
    always_comb begin
        reject_next = (wr_ctrl_res && !res_ok) ||
                      (wr_sub_sample && !(sample_ok && subclass_ok));
    end

    // ********************************************************
    // next values
    // ********************************************************
    // cs is taken from every write to its register, even one whose resolution is refused
    always_comb begin
        cs_next = cs_reg;
        if (wr_ctrl_res) begin
            cs_next = WR_DATA_I[CS_MSB:CS_LSB];
        end
    end

    // resolution only moves on a legal code, so the framer never sees a bad width
    always_comb begin
        res_next = res_reg;
        if (wr_ctrl_res && res_ok) begin
            res_next = res_wr;
        end
    end

    // subclass moves on its own legal code, whatever the sample field holds
    always_comb begin
        subclass_next = subclass_reg;
        if (wr_sub_sample && subclass_ok) begin
            subclass_next = subclass_wr;
        end
    end

    // bits per sample moves on its own legal code
    always_comb begin
        sample_next = sample_reg;
        if (wr_sub_sample && sample_ok) begin
            sample_next = sample_wr;
        end
    end

    // control-bit enables follow the stored cs code one edge later
    always_comb begin
        ctrl_en_next = ctrl_mask(cs_reg);
    end

    // control bits per sample field
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cs_reg <= CS_RESET;
        end else begin
            cs_reg <= cs_next;
        end
    end

    // converter resolution, stored as bits minus one
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            res_reg <= RES_RESET;
        end else begin
            res_reg <= res_next;
        end
    end

    // subclass field
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            subclass_reg <= SUBCLASS_RESET;
        end else begin
            subclass_reg <= subclass_next;
        end
    end

    // bits per sample field
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sample_reg <= SAMPLE_RESET;
        end else begin
            sample_reg <= sample_next;
        end
    end

    // reject pulse, one cycle after the refused write
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            reject_reg <= 1'b0;
        end else begin
            reject_reg <= reject_next;
        end
    end

    // ********************************************************
    // derived, read-only values
    // ********************************************************
    link_frame_derive u_derive (
        .f_code_i(OCTETS_CODE_I),
        .m_code_i(CONVERTERS_I),
        .np_code_i(sample_reg),
        .s_code_o(spf_next),
        .hd_o(hd_next)
    );

    // registered so software and framer see a settled value; the count trails
    // a change of shape or sample width by one edge, so a read issued right
    // after such a write still returns the old count
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            spf_reg <= SPF_RESET;
        end else begin
            spf_reg <= spf_next;
        end
    end

    // high-density flag, same timing as the count
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            hd_reg <= 1'b0;
        end else begin
            hd_reg <= hd_next;
        end
    end

    // ********************************************************
    // read path
    // ********************************************************
    // read data stands only in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        rd_data_next = '0;
        if (RD_I) begin
            case (ADDR_I)
                // cs on top, reserved bit 5 reads zero
                CTRL_RES_OFS: begin
                    rd_data_next[CS_MSB:CS_LSB] = cs_reg;
                    rd_data_next[RES_MSB:0] = res_reg;
                end
                // subclass on top, bits per sample below
                SUBCLASS_SAMPLE_OFS: begin
                    rd_data_next[SUBCLASS_MSB:SUBCLASS_LSB] = subclass_reg;
                    rd_data_next[SAMPLE_MSB:0] = sample_reg;
                end
                // fixed upper bits, count minus one below
                SAMPLES_FRAME_OFS: begin
                    rd_data_next[SPF_RSVD_MSB:SPF_RSVD_LSB] = SPF_RSVD_VALUE;
                    rd_data_next[FIELD5_MSB:0] = spf_reg;
                end
                // density flag on top, control-word count below
                DENSITY_CTRL_OFS: begin
                    rd_data_next[HD_BIT] = hd_reg;
                    rd_data_next[FIELD5_MSB:0] = CF_VALUE; // no control words are sent
                end
                default: begin
                    rd_data_next = '0;
                end
            endcase
        end
    end

    // read data flop
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // ********************************************************
    // link setting outputs
    // ********************************************************
    // mask is flopped so every output comes straight from a register
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_en_reg <= CTRL_MASK_NONE;
        end else begin
            ctrl_en_reg <= ctrl_en_next;
        end
    end

    // pins are wired straight to their flops, no logic in between
    assign CTRL_BIT_EN_O = ctrl_en_reg;
    assign CTRL_BITS_O = cs_reg;
    assign RESOLUTION_O = res_reg;
    assign SUBCLASS_O = subclass_reg;
    assign SAMPLE_BITS_O = sample_reg;
    assign SAMPLES_PER_FRAME_O = spf_reg;
    assign HIGH_DENSITY_O = hd_reg;
    assign RD_DATA_O = rd_data_reg;
    assign WR_REJECT_O = reject_reg;

endmodule : jesd_link_param_regs

// *** link_param_pkg.sv ***
// constants for the link parameter register slice
package link_param_pkg;

    // ********************************************************
    // bus geometry
    // ********************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [11:0] CTRL_RES_OFS = 12'h58f;
    localparam logic [11:0] SUBCLASS_SAMPLE_OFS = 12'h590;
    localparam logic [11:0] SAMPLES_FRAME_OFS = 12'h591;
    localparam logic [11:0] DENSITY_CTRL_OFS = 12'h592;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int CS_MSB = 7;
    localparam int CS_LSB = 6;
    localparam int RES_MSB = 4;
    localparam int SUBCLASS_MSB = 7;
    localparam int SUBCLASS_LSB = 5;
    localparam int SAMPLE_MSB = 4;
    localparam int FIELD5_MSB = 4;
    localparam int SPF_RSVD_MSB = 7;
    localparam int SPF_RSVD_LSB = 5;
    localparam int HD_BIT = 7;

    // ********************************************************
    // reset values and legal codes
    // ********************************************************
    localparam logic [1:0] CS_RESET = 2'h0;
    localparam logic [4:0] RES_RESET = 5'h0f;
    localparam logic [4:0] RES_CODE_MIN = 5'h06;
    localparam logic [4:0] RES_CODE_MAX = 5'h0f;
    localparam logic [2:0] SUBCLASS_RESET = 3'h1;
    localparam logic [2:0] SUBCLASS_0 = 3'h0;
    localparam logic [2:0] SUBCLASS_1 = 3'h1;
    localparam logic [4:0] SAMPLE_CODE_8 = 5'h07;
    localparam logic [4:0] SAMPLE_CODE_12 = 5'h0b;
    localparam logic [4:0] SAMPLE_CODE_16 = 5'h0f;
    localparam logic [4:0] SAMPLE_RESET = 5'h0f;
    localparam logic [4:0] SPF_RESET = 5'h00;
    localparam logic [2:0] SPF_RSVD_VALUE = 3'h1;
    localparam logic [4:0] CF_VALUE = 5'h00;
    localparam logic [7:0] OCTET_BITS = 8'h08;

    // ********************************************************
    // control-bit lane masks per cs code
    // ********************************************************
    localparam logic [2:0] CTRL_MASK_NONE = 3'h0;
    localparam logic [2:0] CTRL_MASK_ONE = 3'h4;
    localparam logic [2:0] CTRL_MASK_TWO = 3'h6;
    localparam logic [2:0] CTRL_MASK_ALL = 3'h7;

    typedef enum logic [1:0] {
        CS_NONE,
        CS_ONE,
        CS_TWO,
        CS_ALL
    } ctrl_bits_e;

endpackage : link_param_pkg

// *** link_frame_derive.sv ***
// derives samples per frame cycle and high-density flag from link shape
`timescale 1ns/1ps
module link_frame_derive
    import link_param_pkg::*;
(
    // link shape from neighbouring settings
    input wire logic [7:0] f_code_i,
    input wire logic [7:0] m_code_i,
    input wire logic [4:0] np_code_i,
    // derived values
    output logic [4:0] s_code_o,
    output logic hd_o
);

    // ********************************************************
    // arithmetic
    // ********************************************************
    logic [15:0] frame_bits;
    logic [15:0] conv_bits;
    logic [15:0] samples;

    // unsigned quotient, zero divisor yields zero
    function automatic logic [15:0] quot(input logic [15:0] num, input logic [15:0] den);
        quot = (den == 16'h0000) ? 16'h0000 : num / den;
    endfunction : quot

    // one frame carries (f+1) octets on every lane of the link
    always_comb begin
        frame_bits = 16'((f_code_i + 9'h001) * OCTET_BITS);
        conv_bits = 16'(m_code_i * (np_code_i + 6'h01));
        samples = quot(frame_bits, conv_bits);
    end

    // field holds count minus one; an empty or oversized result clamps
    always_comb begin
        if (samples == 16'h0000) begin
            s_code_o = SPF_RESET;
        end else if (samples > 16'h0020) begin
            s_code_o = 5'h1f;
        end else begin
            s_code_o = 5'(samples - 16'h0001);
        end
    end

    // a sample wider than one frame must spread over lanes
    assign hd_o = (frame_bits < 16'(np_code_i + 6'h01));

endmodule : link_frame_derive

// *** link_param_props.sv ***
// assertion checker for the link parameter register slice
`timescale 1ns/1ps
module link_param_props
    import link_param_pkg::*;
(
    // clock, reset, register port
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [DATA_W-1:0] RD_DATA_O,
    input wire logic WR_REJECT_O,
    // link settings
    input wire logic [2:0] CTRL_BIT_EN_O,
    input wire logic [1:0] CTRL_BITS_O,
    input wire logic [4:0] RESOLUTION_O,
    input wire logic [2:0] SUBCLASS_O,
    input wire logic [4:0] SAMPLE_BITS_O,
    input wire logic [4:0] SAMPLES_PER_FRAME_O,
    input wire logic HIGH_DENSITY_O
);
    // *****
    // properties
    // *****
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);
    // mask lags the cs code by one stage, so compare against the code one edge back
    a_cs_mask_map: assert property (CTRL_BIT_EN_O == {$past(CTRL_BITS_O) != 2'h0,
        $past(CTRL_BITS_O) > 2'h1, $past(CTRL_BITS_O) == 2'h3}) else $error("cs mask wrong");
    a_res_legal: assert property (RESOLUTION_O inside {[RES_CODE_MIN:RES_CODE_MAX]})
        else $error("resolution code illegal");
    a_sample_legal: assert property (SAMPLE_BITS_O inside {5'h07, 5'h0b, 5'h0f})
        else $error("sample code illegal");
    a_subclass_legal: assert property (SUBCLASS_O <= 3'h1)
        else $error("subclass code illegal");
    a_res_write: assert property (WR_I && ADDR_I == CTRL_RES_OFS && WR_DATA_I[4:0] inside
        {[5'h06:5'h0f]} |=> RESOLUTION_O == $past(WR_DATA_I[4:0])
        && CTRL_BITS_O == $past(WR_DATA_I[7:6])) else $error("legal write not stored");
    a_res_refuse: assert property (WR_I && ADDR_I == CTRL_RES_OFS && !(WR_DATA_I[4:0]
        inside {[5'h06:5'h0f]}) |=> $stable(RESOLUTION_O) && WR_REJECT_O)
        else $error("bad resolution taken");
    a_spf_read: assert property ($past(RD_I) && $past(ADDR_I) == SAMPLES_FRAME_OFS
        |-> RD_DATA_O == {3'h1, $past(SAMPLES_PER_FRAME_O)}) else $error("spf read wrong");
    a_cs_read: assert property ($past(RD_I) && $past(ADDR_I) == CTRL_RES_OFS
        |-> RD_DATA_O == {$past(CTRL_BITS_O), 1'h0, $past(RESOLUTION_O)})
        else $error("cs read wrong");
    c_cs_all: cover property (CTRL_BITS_O == 2'h3);
    c_refuse: cover property (WR_REJECT_O);
    c_dense: cover property (HIGH_DENSITY_O);
endmodule : link_param_props

bind jesd_link_param_regs link_param_props link_param_props_i (.MCLK_I, .NRST_I, .ADDR_I,
    .WR_DATA_I, .WR_I, .RD_I, .RD_DATA_O, .WR_REJECT_O, .CTRL_BIT_EN_O, .CTRL_BITS_O,
    .RESOLUTION_O, .SUBCLASS_O, .SAMPLE_BITS_O, .SAMPLES_PER_FRAME_O, .HIGH_DENSITY_O);

// *** link_rx_model.sv ***
// far-side receiver model: holds link shape, counts control bits per sample
`timescale 1ns/1ps
module link_rx_model (
    // shape chosen by the bench, enables from the framer
    input wire logic [7:0] f_code_i,
    input wire logic [7:0] m_i,
    input wire logic [2:0] ctrl_en_i,
    // shape back to the transmitter, control-bit count
    output logic [7:0] octets_o,
    output logic [7:0] conv_o,
    output logic [1:0] ctrl_count_o
);
    // shape is static level data, so it passes straight through
    assign octets_o = f_code_i;
    assign conv_o = m_i;
    // receiver strips this many control bits from each sample
    assign ctrl_count_o = {1'h0, ctrl_en_i[2]} + {1'h0, ctrl_en_i[1]}
        + {1'h0, ctrl_en_i[0]};
endmodule : link_rx_model

// *** tb.sv ***
// self-checking bench for the link parameter register slice
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb
    import link_param_pkg::*;
;
    logic mclk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, rej, hd;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00, f_code = 8'h07, m_val = 8'h01, rdata, octets, conv;
    logic [2:0] cen, sub;
    logic [1:0] cbits, ccount;
    logic [4:0] res, nbits, spf;
    int n_mismatch = 0;
    int checks_done = 0;
    always #5 mclk = ~mclk;
    jesd_link_param_regs jesd_link_param_regs_i (.MCLK_I(mclk), .NRST_I(nrst), .ADDR_I(addr),
        .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .WR_REJECT_O(rej),
        .OCTETS_CODE_I(octets), .CONVERTERS_I(conv), .CTRL_BIT_EN_O(cen), .CTRL_BITS_O(cbits),
        .RESOLUTION_O(res), .SUBCLASS_O(sub), .SAMPLE_BITS_O(nbits),
        .SAMPLES_PER_FRAME_O(spf), .HIGH_DENSITY_O(hd));
    link_rx_model link_rx_model_i (.f_code_i(f_code), .m_i(m_val), .ctrl_en_i(cen),
        .octets_o(octets), .conv_o(conv), .ctrl_count_o(ccount));
    // *****
    // bus tasks: strobes last one cycle, results checked once the edge has landed
    // *****
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        `CHK("read data", e, rdata)
    endtask : rd_chk
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    // *****
    // scenarios
    // *****
    task automatic t_reset();
        `CHK("cs", 2'h0, cbits)
        `CHK("sub", 3'h1, sub)
        `CHK("mask", 3'h0, cen)
        `CHK("reject", 1'h0, rej)
        rd_chk(CTRL_RES_OFS, 8'h0f);
        rd_chk(SUBCLASS_SAMPLE_OFS, 8'h2f);
    endtask : t_reset
    task automatic t_cs();
        logic [2:0] mask [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
        for (int i = 0; i < 4; i++) begin
            wr_reg(CTRL_RES_OFS, {i[1:0], 6'h0d});
            @(posedge mclk);
            #1;
            `CHK("mask", mask[i], cen)
            `CHK("count", i[1:0], ccount)
            rd_chk(CTRL_RES_OFS, {i[1:0], 6'h0d});
        end
    endtask : t_cs
    task automatic t_res();
        logic [4:0] code [5] = '{5'h06, 5'h0f, 5'h05, 5'h10, 5'h1f};
        for (int i = 0; i < 5; i++) begin
            wr_reg(CTRL_RES_OFS, {i[1:0], 1'h0, code[i]});
            `CHK("res", (i == 0) ? 5'h06 : 5'h0f, res)
            `CHK("cs", i[1:0], cbits)
            `CHK("reject", i > 1, rej)
        end
    endtask : t_res
    task automatic t_sample();
        logic [7:0] d [6] = '{8'h07, 8'h2b, 8'h48, 8'h4f, 8'h08, 8'h0f};
        logic [7:0] e [6] = '{8'h07, 8'h2b, 8'h2b, 8'h2f, 8'h0f, 8'h0f};
        for (int i = 0; i < 6; i++) begin
            wr_reg(SUBCLASS_SAMPLE_OFS, d[i]);
            `CHK("nbits", e[i][4:0], nbits)
            `CHK("sub", e[i][7:5], sub)
            `CHK("reject", i inside {[2:4]}, rej)
        end
    endtask : t_sample
    task automatic t_spf();
        // F=8, M=1, N'=16 gives S=4; F=1 gives S=0 with high density
        wr_reg(SAMPLES_FRAME_OFS, 8'hff);
        repeat (2) @(posedge mclk);
        rd_chk(SAMPLES_FRAME_OFS, 8'h23);
        rd_chk(DENSITY_CTRL_OFS, 8'h00);
        `CHK("spf", 5'h03, spf)
        `CHK("hd", 1'h0, hd)
        @(posedge mclk);
        f_code <= 8'h00;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("spf", 5'h00, spf)
        `CHK("hd", 1'h1, hd)
        rd_chk(SAMPLES_FRAME_OFS, 8'h20);
        rd_chk(DENSITY_CTRL_OFS, 8'h80);
        rd_chk(12'h593, 8'h00);
    endtask : t_spf
    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'h1;
        @(posedge mclk);
        #1;
        t_reset();
        t_cs();
        t_res();
        t_sample();
        t_spf();
        test_done();
    end
    // watchdog: the whole run needs about 70 cycles
    initial begin
        #20000;
        n_mismatch++;
        test_done();
    end
endmodule : tb
